/* File: verilog/clock_unit_pkg.sv */
// Constants and types for the clock source and divider unit.
// Assumes one 200 MHz system clock and a synchronous active-high reset.
// How it works
// - Source changeover parks the root clock low, so no runt or glitch appears.
// - Every source level passes two flip-flops before any switching logic reads it.
// - Four selectable sources: watch crystal, main internal, low-power internal, external.
// - Sixteen independent dividers with 16-bit divide values, synchronous to the root.
// - Analog divided clock enable leads the digital ones by one cycle.
// - Main oscillator frequency resets to 24 MHz; accepts 3 to 48 MHz steps.
// - Main oscillator trim loads from nonvolatile value; software may rewrite it later.
// - Low-power oscillator counters measure main oscillator edges for calibration.
// - Watch crystal keeps running in deep sleep for timekeeping and watchdog.
// - Low-power oscillator clocks peripherals that must run in deep sleep.
package clock_unit_pkg;
	localparam int NUM_DIV = 16;
	localparam int DIV_W = 16;
	localparam int TRIM_W = 8;
	localparam int FREQ_W = 6;
	localparam int CAL_W = 24;
	localparam int NUM_SRC = 4;
	localparam logic [FREQ_W-1:0] FREQ_RESET = 6'h18;
	localparam logic [FREQ_W-1:0] FREQ_MIN = 6'h03;
	localparam logic [FREQ_W-1:0] FREQ_MAX = 6'h30;
	localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
	localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h00;
	localparam int ANALOG_DIV = 0;
	// Source index positions in the synchroniser vector
	localparam int SRC_WATCH = 0;
	localparam int SRC_MAIN = 1;
	localparam int SRC_LP = 2;
	localparam int SRC_EXT = 3;

	typedef enum logic [1:0] {
		SEL_WATCH_CRYSTAL,
		SEL_MAIN_INTERNAL,
		SEL_LOW_POWER_INTERNAL,
		SEL_EXTERNAL
	} src_sel_t;

	typedef enum {
		SW_RUN,
		SW_PARK,
		SW_ENGAGE
	} switch_state_t;
endpackage

/* File: verilog/divider_bank_if.sv */
// Carrier between the clock unit and its divider bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface divider_bank_if;
	import clock_unit_pkg::*;
	logic               root_tick;
	logic [NUM_DIV-1:0] enable;
	logic [DIV_W-1:0]   div_val [NUM_DIV];
	logic [NUM_DIV-1:0] tick;

	modport bank (
		input  root_tick,
		input  enable,
		input  div_val,
		output tick
	);
	modport ctrl (
		output root_tick,
		output enable,
		output div_val,
		input  tick
	);
endinterface

/* File: verilog/divider_bank.sv */
// Sixteen root-tick dividers producing one-cycle output pulses.
// Assumes root_tick is a one-cycle pulse per root clock rising edge.
`timescale 1ns/1ps
module divider_bank
	import clock_unit_pkg::*;
(
	input  wire logic     clock_i,
	input  wire logic     srst_i,
	divider_bank_if.bank  dv
);
	logic [DIV_W-1:0] count [NUM_DIV];

	// Pulse once every div_val+1 root ticks; reload keeps phase exact
	always_ff @(posedge clock_i) begin
		for (int i = 0; i < NUM_DIV; i++) begin
			if (srst_i || !dv.enable[i]) begin
				count[i] <= DIV_RESET;
				dv.tick[i] <= 1'b0;
			end else if (dv.root_tick) begin
				if (count[i] >= dv.div_val[i]) begin
					count[i] <= DIV_RESET;
					dv.tick[i] <= 1'b1;
				end else begin
					count[i] <= count[i] + 16'h0001;
					dv.tick[i] <= 1'b0;
				end
			end else begin
				dv.tick[i] <= 1'b0;
			end
		end
	end

	AST_DIV_RELOAD: assert property (@(posedge clock_i) disable iff (srst_i)
		dv.tick[1] && dv.enable[1] |-> count[1] == DIV_RESET)
		else $error("divider 1 did not reload on its pulse");
	AST_DIV_SPACING: assert property (@(posedge clock_i) disable iff (srst_i)
		dv.tick[2] |=> !dv.tick[2])
		else $error("divider pulse longer than one cycle");
endmodule

/* File: verilog/clock_source_and_divider_unit.sv */
// Clock source selection, dividers, oscillator trim and calibration counters.
// Assumes oscillator and external clock levels arrive asynchronously on pins.
`timescale 1ns/1ps
module clock_source_and_divider_unit
	import clock_unit_pkg::*;
(
	input  wire logic               clock_i,
	input  wire logic               srst_i,
	input  wire logic               watch_crystal_osc_i,
	input  wire logic               main_internal_osc_i,
	input  wire logic               low_power_internal_osc_i,
	input  wire logic               ext_clk_i,
	input  wire logic [1:0]         src_sel_i,
	input  wire logic               deep_sleep_i,
	input  wire logic               div_wr_i,
	input  wire logic [3:0]         div_idx_i,
	input  wire logic [DIV_W-1:0]   div_val_i,
	input  wire logic [NUM_DIV-1:0] div_enable_i,
	input  wire logic               freq_wr_i,
	input  wire logic [FREQ_W-1:0]  freq_mhz_i,
	input  wire logic [TRIM_W-1:0]  nvm_trim_i,
	input  wire logic               trim_wr_i,
	input  wire logic [TRIM_W-1:0]  trim_i,
	input  wire logic               cal_start_i,
	input  wire logic [DIV_W-1:0]   cal_window_i,
	input  wire logic               lp_periph_en_i,
	output logic                    high_freq_root_clock_o,
	output logic [1:0]              active_src_o,
	output logic                    switching_o,
	output logic                    analog_clk_en_o,
	output logic [NUM_DIV-2:0]      digital_clk_en_o,
	output logic [FREQ_W-1:0]       main_osc_freq_mhz_o,
	output logic                    freq_reject_o,
	output logic [TRIM_W-1:0]       main_osc_trim_o,
	output logic                    cal_busy_o,
	output logic                    cal_done_o,
	output logic [CAL_W-1:0]        cal_count_o,
	output logic                    watch_crystal_run_o,
	output logic                    watch_crystal_clk_o,
	output logic                    lp_periph_clk_o
);
	function automatic logic rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction

	// Synchroniser; stage1 is read only by stage2
	logic [NUM_SRC-1:0] sync1;
	logic [NUM_SRC-1:0] sync2;
	logic [NUM_SRC-1:0] sync3;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sync3 <= 4'h0;
		end else begin
			sync1 <= {ext_clk_i, low_power_internal_osc_i,
				main_internal_osc_i, watch_crystal_osc_i};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Source switch
	switch_state_t state;
	src_sel_t      cur_src;
	src_sel_t      want_src;
	logic          root_prev;
	logic          cur_lvl;
	logic          want_lvl;

	assign want_src = src_sel_t'(src_sel_i);
	assign cur_lvl = sync2[cur_src];
	assign want_lvl = sync2[want_src];

	// Root only ever stops in its low phase and restarts at a low level
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state <= SW_RUN;
			cur_src <= SEL_MAIN_INTERNAL;
			high_freq_root_clock_o <= 1'b0;
			switching_o <= 1'b0;
		end else begin
			unique case (state)
				SW_RUN: begin
					high_freq_root_clock_o <= cur_lvl;
					if (want_src != cur_src) begin
						state <= SW_PARK;
						switching_o <= 1'b1;
					end
				end
				SW_PARK: begin
					if (!cur_lvl) begin
						high_freq_root_clock_o <= 1'b0;
						cur_src <= want_src;
						state <= SW_ENGAGE;
					end else begin
						high_freq_root_clock_o <= cur_lvl;
					end
				end
				SW_ENGAGE: begin
					high_freq_root_clock_o <= 1'b0;
					if (want_src != cur_src) begin
						cur_src <= want_src;
					end else if (!cur_lvl) begin
						state <= SW_RUN;
						// Flag tracks the state register exactly, but from a flop
						switching_o <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			root_prev <= 1'b0;
		end else begin
			root_prev <= high_freq_root_clock_o;
		end
	end

	assign active_src_o = cur_src;

	// Divider configuration and bank
	divider_bank_if dv ();
	logic [NUM_DIV-2:0] dig_stage;

	assign dv.root_tick = rise(high_freq_root_clock_o, root_prev);
	assign dv.enable = div_enable_i;

	always_ff @(posedge clock_i) begin
		for (int i = 0; i < NUM_DIV; i++) begin
			if (srst_i) begin
				dv.div_val[i] <= DIV_RESET;
			end else if (div_wr_i && div_idx_i == 4'(i)) begin
				dv.div_val[i] <= div_val_i;
			end
		end
	end

	divider_bank u_bank (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.dv      (dv.bank)
	);

	// Digital enables pass an extra stage so analog settles first
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			analog_clk_en_o <= 1'b0;
			dig_stage <= '0;
			digital_clk_en_o <= '0;
		end else begin
			analog_clk_en_o <= dv.tick[ANALOG_DIV];
			dig_stage <= dv.tick[NUM_DIV-1:1];
			digital_clk_en_o <= dig_stage;
		end
	end

	// Main oscillator frequency setting
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			main_osc_freq_mhz_o <= FREQ_RESET;
			freq_reject_o <= 1'b0;
		end else begin
			freq_reject_o <= 1'b0;
			if (freq_wr_i) begin
				if (freq_mhz_i >= FREQ_MIN && freq_mhz_i <= FREQ_MAX) begin
					main_osc_freq_mhz_o <= freq_mhz_i;
				end else begin
					freq_reject_o <= 1'b1;
				end
			end
		end
	end

	// Trim: stored value taken once after reset release, then software owns it
	logic trim_loaded;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			trim_loaded <= 1'b0;
			main_osc_trim_o <= TRIM_RESET;
		end else if (!trim_loaded) begin
			trim_loaded <= 1'b1;
			main_osc_trim_o <= nvm_trim_i;
		end else if (trim_wr_i) begin
			main_osc_trim_o <= trim_i;
		end
	end

	// Calibration: main edges counted across a window of low-power edges
	logic [DIV_W-1:0] cal_lp_cnt;
	logic [CAL_W-1:0] cal_main_cnt;
	logic             lp_edge;
	logic             main_edge;

	assign lp_edge = rise(sync2[SRC_LP], sync3[SRC_LP]);
	assign main_edge = rise(sync2[SRC_MAIN], sync3[SRC_MAIN]);

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			cal_busy_o <= 1'b0;
			cal_done_o <= 1'b0;
			cal_lp_cnt <= '0;
			cal_main_cnt <= '0;
			cal_count_o <= '0;
		end else begin
			cal_done_o <= 1'b0;
			if (!cal_busy_o) begin
				if (cal_start_i) begin
					cal_busy_o <= 1'b1;
					cal_lp_cnt <= '0;
					cal_main_cnt <= '0;
				end
			end else begin
				if (main_edge) begin
					cal_main_cnt <= cal_main_cnt + 24'h000001;
				end
				if (lp_edge) begin
					if (cal_lp_cnt + 16'h0001 >= cal_window_i) begin
						cal_busy_o <= 1'b0;
						cal_done_o <= 1'b1;
						cal_count_o <= cal_main_cnt + {23'h0, main_edge};
					end else begin
						cal_lp_cnt <= cal_lp_cnt + 16'h0001;
					end
				end
			end
		end
	end

	// Low-frequency clocks never depend on deep sleep
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			watch_crystal_run_o <= 1'b0;
			watch_crystal_clk_o <= 1'b0;
			lp_periph_clk_o <= 1'b0;
		end else begin
			watch_crystal_run_o <= 1'b1;
			watch_crystal_clk_o <= sync2[SRC_WATCH];
			lp_periph_clk_o <= lp_periph_en_i & sync2[SRC_LP];
		end
	end

	AST_PARK_LOW: assert property (@(posedge clock_i) disable iff (srst_i)
		state == SW_ENGAGE |=> !high_freq_root_clock_o)
		else $error("root clock high while arming a new source");
	AST_SWAP_AT_LOW: assert property (@(posedge clock_i) disable iff (srst_i)
		$changed(cur_src) |-> !high_freq_root_clock_o)
		else $error("source changed while root clock high");
	AST_FOLLOW_SOURCE: assert property (@(posedge clock_i) disable iff (srst_i)
		state == SW_RUN && $past(state) == SW_RUN && $stable(cur_src)
		|=> high_freq_root_clock_o == $past(sync2[cur_src]))
		else $error("root clock not following selected source");
	AST_ANALOG_LEAD: assert property (@(posedge clock_i) disable iff (srst_i)
		dv.tick[ANALOG_DIV] && dv.tick[1] |=> analog_clk_en_o && !digital_clk_en_o[0]
		##1 digital_clk_en_o[0])
		else $error("analog enable did not lead digital enable");
	AST_FREQ_REJECT: assert property (@(posedge clock_i) disable iff (srst_i)
		freq_wr_i && (freq_mhz_i < FREQ_MIN || freq_mhz_i > FREQ_MAX)
		|=> $stable(main_osc_freq_mhz_o) && freq_reject_o)
		else $error("out of range frequency accepted");
	AST_TRIM_LOAD: assert property (@(posedge clock_i) disable iff (srst_i)
		$rose(trim_loaded) |-> main_osc_trim_o == $past(nvm_trim_i))
		else $error("stored trim not loaded");
	AST_CAL_DONE: assert property (@(posedge clock_i) disable iff (srst_i)
		cal_done_o |-> !cal_busy_o && $past(cal_busy_o) && $past(lp_edge))
		else $error("calibration done without window end");
	AST_WATCH_RUNS: assert property (@(posedge clock_i) disable iff (srst_i)
		deep_sleep_i ##1 1'b1 |-> watch_crystal_run_o)
		else $error("watch crystal stopped in deep sleep");
	AST_LP_CLOCK: assert property (@(posedge clock_i) disable iff (srst_i)
		lp_periph_en_i && sync2[SRC_LP] |=> lp_periph_clk_o)
		else $error("low-power peripheral clock not driven");
endmodule

/* File: tb/periph_clock_sink.sv */
// Peripheral side model: consumes the divided clock enables.
// Assumes enables are one-cycle pulses synchronous to clock_i.
`timescale 1ns/1ps
module periph_clock_sink
	import clock_unit_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              srst_i,
	input  wire logic              analog_en_i,
	input  wire logic [NUM_DIV-2:0] digital_en_i,
	output logic [15:0]            analog_period_o,
	output logic [15:0]            lead_o
);
	logic [15:0] since;

	// Cycles since the last analog pulse; digital pulse reports its lag
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			since <= 16'h0000;
			analog_period_o <= 16'h0000;
			lead_o <= 16'hffff;
		end else begin
			since <= analog_en_i ? 16'h0001 : since + 16'h0001;
			if (analog_en_i)
				analog_period_o <= since;
			if (digital_en_i[0])
				lead_o <= since;
		end
	end
endmodule

/* File: tb/clock_source_and_divider_unit_tb.sv */
// Self-checking bench for the clock source and divider unit.
// Assumes free-running oscillator levels with unrelated phases.
`timescale 1ns/1ps
module clock_source_and_divider_unit_tb;
	import clock_unit_pkg::*;
	logic clock_i = 0, srst_i = 1, wxtal = 0, mosc = 0, lposc = 0, ext = 0;
	logic [1:0] src_sel = 2'h1;
	logic deep_sleep = 0, div_wr = 0, freq_wr = 0, trim_wr = 0, cal_start = 0, lp_en = 0;
	logic [3:0] div_idx = 4'h0;
	logic [DIV_W-1:0] div_val = 16'h0000, cal_window = 16'h0000;
	logic [NUM_DIV-1:0] div_en = 16'h0000;
	logic [FREQ_W-1:0] freq = 6'h00;
	logic [TRIM_W-1:0] trim = 8'h00;
	logic [TRIM_W-1:0] nvm = 8'h5a;
	logic root, sw, a_en, rej, busy, done, wrun, wclk, lpclk;
	logic [1:0] act;
	logic [NUM_DIV-2:0] d_en;
	logic [FREQ_W-1:0] freq_o;
	logic [TRIM_W-1:0] trim_o;
	logic [CAL_W-1:0] cal_cnt;
	logic [15:0] a_per, lead;
	int err_total = 0, total_checks = 0, run = 0, k;
	logic seen0, seen1;

	always #2.5 clock_i = ~clock_i;
	// Oscillator rates chosen so every source is several cycles wide
	always #20 mosc = ~mosc;
	always #80.3 lposc = ~lposc;
	always #101.7 wxtal = ~wxtal;
	always #31.1 ext = ~ext;

	clock_source_and_divider_unit i_dut (.clock_i(clock_i), .srst_i(srst_i),
		.watch_crystal_osc_i(wxtal), .main_internal_osc_i(mosc),
		.low_power_internal_osc_i(lposc), .ext_clk_i(ext), .src_sel_i(src_sel),
		.deep_sleep_i(deep_sleep), .div_wr_i(div_wr), .div_idx_i(div_idx),
		.div_val_i(div_val), .div_enable_i(div_en), .freq_wr_i(freq_wr),
		.freq_mhz_i(freq), .nvm_trim_i(nvm), .trim_wr_i(trim_wr), .trim_i(trim),
		.cal_start_i(cal_start), .cal_window_i(cal_window), .lp_periph_en_i(lp_en),
		.high_freq_root_clock_o(root), .active_src_o(act), .switching_o(sw),
		.analog_clk_en_o(a_en), .digital_clk_en_o(d_en), .main_osc_freq_mhz_o(freq_o),
		.freq_reject_o(rej), .main_osc_trim_o(trim_o), .cal_busy_o(busy),
		.cal_done_o(done), .cal_count_o(cal_cnt), .watch_crystal_run_o(wrun),
		.watch_crystal_clk_o(wclk), .lp_periph_clk_o(lpclk));

	periph_clock_sink i_sink (.clock_i(clock_i), .srst_i(srst_i), .analog_en_i(a_en),
		.digital_en_i(d_en), .analog_period_o(a_per), .lead_o(lead));

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic write_freq(input logic [FREQ_W-1:0] v, input logic [FREQ_W-1:0] exp,
		input logic exp_rej);
		freq_wr = 1;
		freq = v;
		tick(1);
		freq_wr = 0;
		check(rej, exp_rej);
		check(freq_o, exp);
		// Idle cycle so back-to-back writes never retoggle the strobe in one step
		tick(1);
	endtask

	task automatic select(input logic [1:0] s);
		src_sel = s;
		tick(2);
		for (k = 0; k < 400 && sw !== 1'b0; k++)
			tick(1);
		if (k == 400) begin
			err_total++;
			end_of_test();
		end
		check(act, s);
	endtask

	task automatic watch_toggle(input logic which);
		seen0 = 0;
		seen1 = 0;
		repeat (100) begin
			tick(1);
			if ((which ? lpclk : wclk) === 1'b0) seen0 = 1;
			if ((which ? lpclk : wclk) === 1'b1) seen1 = 1;
		end
		if (which)
			check({seen0, seen1}, 2'h3);
		else
			check({seen0, seen1}, 2'h3);
	endtask

	// Runt detector: a root high phase must span at least two cycles
	always @(posedge clock_i) begin
		if (srst_i)
			run = 0;
		else if (root === 1'b1)
			run++;
		else begin
			if (run != 0)
				check(run >= 2, 1'b1);
			run = 0;
		end
	end

	initial begin
		tick(6);
		srst_i = 0;
		tick(2);
		check(freq_o, FREQ_RESET);
		check(act, 2'h1);
		check(trim_o, 8'h5a);
		check(wrun, 1'b1);
		trim_wr = 1;
		trim = 8'hc3;
		tick(1);
		trim_wr = 0;
		check(trim_o, 8'hc3);
		write_freq(6'h03, 6'h03, 0);
		write_freq(6'h02, 6'h03, 1);
		write_freq(6'h30, 6'h30, 0);
		write_freq(6'h31, 6'h30, 1);
		// Dividers 0 and 1 at ratio 2: one pulse per 16 cycles of an 8-cycle root
		// Divider 2 stays at its reset value, one pulse per root tick
		for (int i = 0; i < 2; i++) begin
			div_wr = 1;
			div_idx = i[3:0];
			div_val = 16'h0001;
			tick(1);
		end
		div_wr = 0;
		div_en = 16'h0007;
		tick(200);
		check(a_per, 16'h0010);
		check(lead, 16'h0001);
		cal_window = 16'h0004;
		cal_start = 1;
		tick(1);
		cal_start = 0;
		check(busy, 1'b1);
		for (k = 0; k < 1000 && done !== 1'b1; k++)
			tick(1);
		check(k < 1000 && cal_cnt >= 12 && cal_cnt <= 17, 1'b1);
		check({busy, done}, 2'h1);
		if (k == 1000)
			end_of_test();
		deep_sleep = 1;
		lp_en = 1;
		watch_toggle(0);
		check(wrun, 1'b1);
		watch_toggle(1);
		lp_en = 0;
		tick(2);
		check(lpclk, 1'b0);
		deep_sleep = 0;
		select(2'h0);
		select(2'h3);
		select(2'h2);
		select(2'h1);
		// Second reset: stored trim recaptured, frequency back to default
		srst_i = 1;
		nvm = 8'h3c;
		tick(3);
		srst_i = 0;
		tick(2);
		check(trim_o, 8'h3c);
		check(freq_o, FREQ_RESET);
		check({act, sw}, 3'h2);
		end_of_test();
	end
endmodule
